/* File: rtl/cc3_edge.sv */
// Falling edge detector for the adapter-present flag.
// Assumes the flag is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cc3_edge (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Level in, pulse out
  input  wire logic level_in,
  output logic      fall_pulse
);
  logic level_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_in;
    end
  end

  assign fall_pulse = level_q & ~level_in;
endmodule
`default_nettype wire

/* File: rtl/cc3_pkg.sv */
// Constants and field layout of the charger control three register.
// Assumes a single 200 MHz clock and an SMBus engine outside that hands over decoded register accesses.
package cc3_pkg;
  localparam logic [7:0]  CC3_OFFSET        = 8'h4c;
  localparam int          CC3_WIDTH         = 16;
  localparam int          CC3_B_OV_OFF      = 15;
  localparam int          CC3_B_NO_RELOAD   = 14;
  localparam int          CC3_B_TERM_LONG   = 13;
  localparam int          CC3_B_TO_HI       = 12;
  localparam int          CC3_B_TO_LO       = 11;
  localparam int          CC3_B_HYST        = 10;
  localparam int          CC3_B_GAIN_HI     = 9;
  localparam int          CC3_B_GAIN_LO     = 8;
  localparam int          CC3_B_AUTO        = 7;
  localparam int          CC3_B_FB_HALF     = 6;
  localparam int          CC3_B_ICL_OFF     = 5;
  localparam int          CC3_B_ACL_BATOFF  = 4;
  localparam int          CC3_B_CURRENT_MONITOR_OUTPUT_REV    = 3;
  localparam int          CC3_B_DRESET      = 2;
  localparam int          CC3_B_T2_NORMAL   = 1;
  localparam int          CC3_B_ADC_ALWAYS  = 0;
  localparam logic [15:0] CC3_RESET         = 16'h0300;
  localparam logic [15:0] CC3_WMASK         = 16'hfffb;
  localparam int          CC3_CLK_MHZ       = 200;
  localparam int          CC3_TERM_SHORT_MS = 20;
  localparam int          CC3_TERM_LONG_MS  = 200;
  localparam int          CC3_TERM_SHORT_CY = CC3_TERM_SHORT_MS * 1000 * CC3_CLK_MHZ;
  localparam int          CC3_TERM_LONG_CY  = CC3_TERM_LONG_MS * 1000 * CC3_CLK_MHZ;
  localparam int          CC3_DRESET_CY     = 4;
  localparam logic [1:0]  CC3_TO_175S       = 2'h0;
  localparam logic [1:0]  CC3_TO_87S5       = 2'h1;
  localparam logic [1:0]  CC3_TO_43S75      = 2'h2;
  localparam logic [1:0]  CC3_TO_4S95       = 2'h3;
  localparam logic [63:0] CC3_TO_175S_CY    = 64'd175 * 64'd200000000;
  localparam logic [63:0] CC3_TO_87S5_CY    = 64'd875 * 64'd20000000;
  localparam logic [63:0] CC3_TO_43S75_CY   = 64'd4375 * 64'd2000000;
  localparam logic [63:0] CC3_TO_4S95_CY    = 64'd495 * 64'd2000000;
  typedef enum logic [1:0] {
    CC3_IDLE  = 2'b00,
    CC3_RESET_ST = 2'b01,
    CC3_LOAD  = 2'b10
  } cc3_state_t;
endpackage

/* File: rtl/cc3_reg.sv */
// Charger control three register and the control outputs it steers.
// Assumes an SMBus engine gives one-cycle write strobes and samples read data one cycle after a read strobe.
`timescale 1ns/1ps
`default_nettype none
module cc3_reg (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register access from the SMBus engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic             reg_hit,
  // Charger status inputs
  input  wire logic        adapter_present_flag,
  input  wire logic        battery_absent_input,
  input  wire logic        charging_active,
  input  wire logic        charge_timer_12h_expired,
  input  wire logic        fault_any,
  input  wire logic        ov_detected_debounced,
  input  wire logic        current_monitor_output_select_battery,
  input  wire logic [7:0]  config_resistor_limit,
  // Control outputs
  output logic             switching_stop,
  output logic             uv_ov_checks_enable,
  output logic             adapter_limit_reload,
  output logic [7:0]       adapter_limit_one_reg,
  output logic [63:0]      term_time_cycles,
  output logic [63:0]      smbus_timeout_cycles,
  output logic             dcm_ccm_hysteresis,
  output logic [1:0]       system_power_monitor_gain,
  output logic             autonomous_mode,
  output logic             end_of_charge_enable,
  output logic             hot_alert_is_auto_indicator,
  output logic             feedback_gain_half,
  output logic             input_limit_loop_enable,
  output logic             adapter_current_limit_enable,
  output logic             monitor_reverse,
  output logic             monitor_battery,
  output logic             digital_reset_pulse,
  output logic             config_resistor_reread,
  output logic             dcm_t2_interval_select,
  output logic             adc_run
);
  logic [15:0]           ctl_q;
  cc3_pkg::cc3_state_t   st_q;
  logic                  rst_done;
  logic                  fall;
  logic                  wr_hit;

  function automatic logic [63:0] timeout_cycles(input logic [1:0] sel);
    case (sel)
      cc3_pkg::CC3_TO_175S:  timeout_cycles = cc3_pkg::CC3_TO_175S_CY;
      cc3_pkg::CC3_TO_87S5:  timeout_cycles = cc3_pkg::CC3_TO_87S5_CY;
      cc3_pkg::CC3_TO_43S75: timeout_cycles = cc3_pkg::CC3_TO_43S75_CY;
      default:               timeout_cycles = cc3_pkg::CC3_TO_4S95_CY;
    endcase
  endfunction

  cc3_edge u_edge (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .level_in   (adapter_present_flag),
    .fall_pulse (fall)
  );

  // The timer needs two cycles to load and count out, so it is loaded two short of the hold time.
  cc3_timer u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (st_q == cc3_pkg::CC3_RESET_ST),
    .count   (64'(cc3_pkg::CC3_DRESET_CY - 2)),
    .expired (rst_done)
  );

  assign wr_hit = reg_wr && (reg_addr == cc3_pkg::CC3_OFFSET) && (st_q == cc3_pkg::CC3_IDLE);

  // Register contents and self-clearing of autonomous mode.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl_q <= cc3_pkg::CC3_RESET;
    end else if (st_q == cc3_pkg::CC3_RESET_ST) begin
      ctl_q <= cc3_pkg::CC3_RESET;
    end else begin
      if (wr_hit) begin
        ctl_q <= reg_wdata & cc3_pkg::CC3_WMASK;
      end
      if (charge_timer_12h_expired || fault_any) begin
        ctl_q[cc3_pkg::CC3_B_AUTO] <= 1'b0;
      end
    end
  end

  // Digital reset sequence.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= cc3_pkg::CC3_IDLE;
    end else begin
      case (st_q)
        cc3_pkg::CC3_IDLE: begin
          if (wr_hit && reg_wdata[cc3_pkg::CC3_B_DRESET]) begin
            st_q <= cc3_pkg::CC3_RESET_ST;
          end
        end
        cc3_pkg::CC3_RESET_ST: begin
          if (rst_done) begin
            st_q <= cc3_pkg::CC3_LOAD;
          end
        end
        cc3_pkg::CC3_LOAD: st_q <= cc3_pkg::CC3_IDLE;
        default: st_q <= cc3_pkg::CC3_IDLE;
      endcase
    end
  end

  // Reload of adapter limit one.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      adapter_limit_one_reg <= 8'h00;
      adapter_limit_reload  <= 1'b0;
    end else begin
      adapter_limit_reload <= 1'b0;
      if (st_q == cc3_pkg::CC3_LOAD) begin
        adapter_limit_one_reg <= config_resistor_limit;
      end else if (fall && !ctl_q[cc3_pkg::CC3_B_NO_RELOAD]) begin
        adapter_limit_one_reg <= config_resistor_limit;
        adapter_limit_reload  <= 1'b1;
      end
    end
  end

  // Registered decode of every control field except the no-reload bit, which the reload block uses, and the digital reset bit, which the reset sequence uses.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      switching_stop               <= 1'b0;
      uv_ov_checks_enable          <= 1'b1;
      term_time_cycles             <= 64'(cc3_pkg::CC3_TERM_SHORT_CY);
      smbus_timeout_cycles         <= cc3_pkg::CC3_TO_175S_CY;
      dcm_ccm_hysteresis           <= 1'b0;
      system_power_monitor_gain    <= 2'h3;
      autonomous_mode              <= 1'b0;
      end_of_charge_enable         <= 1'b0;
      hot_alert_is_auto_indicator  <= 1'b0;
      feedback_gain_half           <= 1'b0;
      input_limit_loop_enable      <= 1'b1;
      adapter_current_limit_enable <= 1'b1;
      monitor_reverse              <= 1'b0;
      monitor_battery              <= 1'b0;
      digital_reset_pulse          <= 1'b0;
      config_resistor_reread       <= 1'b0;
      dcm_t2_interval_select       <= 1'b0;
      adc_run                      <= 1'b0;
      reg_rdata                    <= 16'h0000;
      reg_hit                      <= 1'b0;
    end else begin
      uv_ov_checks_enable <= ~ctl_q[cc3_pkg::CC3_B_OV_OFF];
      switching_stop      <= ~ctl_q[cc3_pkg::CC3_B_OV_OFF] & ov_detected_debounced;
      term_time_cycles    <= ctl_q[cc3_pkg::CC3_B_TERM_LONG] ? 64'(cc3_pkg::CC3_TERM_LONG_CY) :
                             64'(cc3_pkg::CC3_TERM_SHORT_CY);
      smbus_timeout_cycles <= timeout_cycles(ctl_q[cc3_pkg::CC3_B_TO_HI:cc3_pkg::CC3_B_TO_LO]);
      dcm_ccm_hysteresis  <= ctl_q[cc3_pkg::CC3_B_HYST];
      system_power_monitor_gain <= ctl_q[cc3_pkg::CC3_B_GAIN_HI:cc3_pkg::CC3_B_GAIN_LO];
      autonomous_mode             <= ctl_q[cc3_pkg::CC3_B_AUTO];
      end_of_charge_enable        <= ctl_q[cc3_pkg::CC3_B_AUTO];
      hot_alert_is_auto_indicator <= ctl_q[cc3_pkg::CC3_B_AUTO];
      feedback_gain_half  <= ctl_q[cc3_pkg::CC3_B_FB_HALF];
      input_limit_loop_enable <= ~ctl_q[cc3_pkg::CC3_B_ICL_OFF];
      adapter_current_limit_enable <= ~(ctl_q[cc3_pkg::CC3_B_ACL_BATOFF] & battery_absent_input);
      monitor_reverse     <= ctl_q[cc3_pkg::CC3_B_CURRENT_MONITOR_OUTPUT_REV];
      monitor_battery     <= current_monitor_output_select_battery;
      digital_reset_pulse    <= (st_q == cc3_pkg::CC3_RESET_ST);
      config_resistor_reread <= (st_q == cc3_pkg::CC3_LOAD);
      dcm_t2_interval_select <= ctl_q[cc3_pkg::CC3_B_T2_NORMAL];
      adc_run <= ctl_q[cc3_pkg::CC3_B_ADC_ALWAYS] | (adapter_present_flag & charging_active);
      reg_hit <= reg_rd && (reg_addr == cc3_pkg::CC3_OFFSET);
      if (reg_rd && (reg_addr == cc3_pkg::CC3_OFFSET)) begin
        reg_rdata <= ctl_q;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  AST_OV_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    ctl_q[cc3_pkg::CC3_B_OV_OFF] |=> !switching_stop && !uv_ov_checks_enable)
    else $error("Overvoltage checks not disabled.");
  AST_RELOAD: assert property (@(posedge ref_clk) disable iff (rst)
    fall && !ctl_q[cc3_pkg::CC3_B_NO_RELOAD] && st_q != cc3_pkg::CC3_LOAD |=>
    adapter_limit_reload && adapter_limit_one_reg == $past(config_resistor_limit))
    else $error("Adapter limit not reloaded.");
  AST_NO_RELOAD: assert property (@(posedge ref_clk) disable iff (rst)
    ctl_q[cc3_pkg::CC3_B_NO_RELOAD] |=> !adapter_limit_reload)
    else $error("Reload happened while suppressed.");
  AST_TERM: assert property (@(posedge ref_clk) disable iff (rst)
    ctl_q[cc3_pkg::CC3_B_TERM_LONG] |=> term_time_cycles == 64'(cc3_pkg::CC3_TERM_LONG_CY))
    else $error("Long termination time not chosen.");
  AST_TO_LONG: assert property (@(posedge ref_clk) disable iff (rst)
    ctl_q[cc3_pkg::CC3_B_TO_HI:cc3_pkg::CC3_B_TO_LO] == cc3_pkg::CC3_TO_175S |=>
    smbus_timeout_cycles == cc3_pkg::CC3_TO_175S_CY)
    else $error("Longest SMBus timeout not chosen.");
  AST_TO_SHORT: assert property (@(posedge ref_clk) disable iff (rst)
    ctl_q[cc3_pkg::CC3_B_TO_HI:cc3_pkg::CC3_B_TO_LO] == cc3_pkg::CC3_TO_4S95 |=>
    smbus_timeout_cycles == cc3_pkg::CC3_TO_4S95_CY)
    else $error("Shortest SMBus timeout not chosen.");
  AST_HYST: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> dcm_ccm_hysteresis == $past(ctl_q[cc3_pkg::CC3_B_HYST]))
    else $error("Hysteresis output does not follow its bit.");
  AST_GAIN: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> system_power_monitor_gain == $past(ctl_q[cc3_pkg::CC3_B_GAIN_HI:cc3_pkg::CC3_B_GAIN_LO]))
    else $error("Power monitor gain does not follow its field.");
  AST_AUTO_ON: assert property (@(posedge ref_clk) disable iff (rst)
    ctl_q[cc3_pkg::CC3_B_AUTO] |=> autonomous_mode && end_of_charge_enable && hot_alert_is_auto_indicator)
    else $error("Autonomous mode outputs not raised.");
  AST_AUTO_CLR: assert property (@(posedge ref_clk) disable iff (rst)
    fault_any |=> !ctl_q[cc3_pkg::CC3_B_AUTO] ##1 !autonomous_mode)
    else $error("Autonomous mode survived a fault.");
  AST_FB_HALF: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> feedback_gain_half == $past(ctl_q[cc3_pkg::CC3_B_FB_HALF]))
    else $error("Feedback gain does not follow its bit.");
  AST_ICL_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    ctl_q[cc3_pkg::CC3_B_ICL_OFF] |=> !input_limit_loop_enable)
    else $error("Input limit loop left on.");
  AST_ACL: assert property (@(posedge ref_clk) disable iff (rst)
    ctl_q[cc3_pkg::CC3_B_ACL_BATOFF] && battery_absent_input |=> !adapter_current_limit_enable)
    else $error("Adapter loop active with battery absent.");
  AST_MON_DIR: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> monitor_reverse == $past(ctl_q[cc3_pkg::CC3_B_CURRENT_MONITOR_OUTPUT_REV]))
    else $error("Monitor direction does not follow its bit.");
  AST_DRESET: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata[cc3_pkg::CC3_B_DRESET] |=> ##4 ctl_q == cc3_pkg::CC3_RESET ##1 config_resistor_reread)
    else $error("Digital reset sequence wrong.");
  AST_RST_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(digital_reset_pulse) |-> digital_reset_pulse[*4] ##1 !digital_reset_pulse)
    else $error("Digital reset pulse has the wrong length.");
  AST_REREAD: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(config_resistor_reread) |-> $past(digital_reset_pulse))
    else $error("Resistor re-read without a digital reset.");
  AST_T2: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> dcm_t2_interval_select == $past(ctl_q[cc3_pkg::CC3_B_T2_NORMAL]))
    else $error("T2 interval select does not follow its bit.");
  AST_ADC: assert property (@(posedge ref_clk) disable iff (rst)
    !ctl_q[cc3_pkg::CC3_B_ADC_ALWAYS] && !adapter_present_flag |=> !adc_run)
    else $error("ADC ran without adapter.");
  AST_MON_SEL: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> monitor_battery == $past(current_monitor_output_select_battery))
    else $error("Monitor source does not follow its select.");
  AST_BIT2_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    reg_hit |-> !reg_rdata[cc3_pkg::CC3_B_DRESET])
    else $error("Digital reset bit read as one.");
  AST_POR: assert property (@(posedge ref_clk)
    rst |=> ctl_q == cc3_pkg::CC3_RESET)
    else $error("Register not at its power-on value after reset.");
endmodule
`default_nettype wire

/* File: rtl/cc3_timer.sv */
// Down counter that pulses once when a loaded count runs out.
// Assumes run and the count come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module cc3_timer (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Control
  input  wire logic        run,
  input  wire logic [63:0] count,
  output logic             expired
);
  logic [63:0] cnt_q;
  logic        run_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= 64'h0;
      run_q   <= 1'b0;
      expired <= 1'b0;
    end else begin
      run_q   <= run;
      expired <= 1'b0;
      if (!run) begin
        cnt_q <= 64'h0;
      end else if (!run_q) begin
        cnt_q <= count;
      end else if (cnt_q == 64'h1) begin
        cnt_q   <= 64'h0;
        expired <= 1'b1;
      end else if (cnt_q != 64'h0) begin
        cnt_q <= cnt_q - 64'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/cc3_host.sv */
// Host stand-in that issues decoded register writes and reads to the block.
// Assumes the block takes a request on the rising ref_clk edge and answers one cycle later.
`timescale 1ns/1ps
`default_nettype none
module cc3_host (
  // Clock
  input  wire logic        ref_clk,
  // Register access
  output logic [7:0]       reg_addr,
  output logic             reg_wr,
  output logic [15:0]      reg_wdata,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_hit
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
  end
  // Idle cycles before a request model a slow host; released data is inverted.
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int gap);
    repeat (gap + 1) @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic h);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
    h = reg_hit;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the charger control three register against a bench model.
// Assumes the host stand-in module and the package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0, rst = 1'b1;
  logic adapter_present_flag = 1'b1, battery_absent_input = 1'b0, charging_active = 1'b0;
  logic charge_timer_12h_expired = 1'b0, fault_any = 1'b0, ov_detected_debounced = 1'b0;
  logic current_monitor_output_select_battery = 1'b0;
  logic [7:0] config_resistor_limit = 8'h00, reg_addr, adapter_limit_one_reg, lim, model_lim;
  logic [15:0] reg_wdata, reg_rdata, model_q, w, d;
  logic reg_wr, reg_rd, reg_hit, h, switching_stop, uv_ov_checks_enable, adapter_limit_reload;
  logic [63:0] term_time_cycles, smbus_timeout_cycles;
  logic [1:0] system_power_monitor_gain;
  logic dcm_ccm_hysteresis, autonomous_mode, end_of_charge_enable, hot_alert_is_auto_indicator;
  logic feedback_gain_half, input_limit_loop_enable, adapter_current_limit_enable, monitor_reverse;
  logic monitor_battery, digital_reset_pulse, config_resistor_reread, dcm_t2_interval_select, adc_run;
  logic [63:0] to_cy [4] = '{64'd35000000000, 64'd17500000000, 64'd8750000000, 64'd990000000};
  int error_cnt = 0, samples_checked = 0, reload_cnt = 0, reread_cnt = 0, pulse_cnt = 0, b, p;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (adapter_limit_reload === 1'b1) reload_cnt <= reload_cnt + 1;
    if (config_resistor_reread === 1'b1) reread_cnt <= reread_cnt + 1;
    if (digital_reset_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
  end
  cc3_host host (.ref_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_hit);
  cc3_reg dut (.ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_hit,
    .adapter_present_flag, .battery_absent_input, .charging_active, .charge_timer_12h_expired,
    .fault_any, .ov_detected_debounced, .current_monitor_output_select_battery, .config_resistor_limit,
    .switching_stop, .uv_ov_checks_enable, .adapter_limit_reload, .adapter_limit_one_reg,
    .term_time_cycles, .smbus_timeout_cycles, .dcm_ccm_hysteresis, .system_power_monitor_gain,
    .autonomous_mode, .end_of_charge_enable, .hot_alert_is_auto_indicator, .feedback_gain_half,
    .input_limit_loop_enable, .adapter_current_limit_enable, .monitor_reverse, .monitor_battery,
    .digital_reset_pulse, .config_resistor_reread, .dcm_t2_interval_select, .adc_run);
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic check_outputs();
    chk("uv_ov_en", !model_q[15], uv_ov_checks_enable);
    chk("sw_stop", !model_q[15] && ov_detected_debounced, switching_stop);
    chk("term", model_q[13] ? 64'd40000000 : 64'd4000000, term_time_cycles);
    chk("timeout", to_cy[model_q[12:11]], smbus_timeout_cycles);
    chk("hyst", model_q[10], dcm_ccm_hysteresis);
    chk("gain", model_q[9:8], system_power_monitor_gain);
    chk("auto", model_q[7], autonomous_mode);
    chk("eoc", model_q[7], end_of_charge_enable);
    chk("hot_ind", model_q[7], hot_alert_is_auto_indicator);
    chk("fb_half", model_q[6], feedback_gain_half);
    chk("icl_en", !model_q[5], input_limit_loop_enable);
    chk("acl_en", !(model_q[4] && battery_absent_input), adapter_current_limit_enable);
    chk("mon_rev", model_q[3], monitor_reverse);
    chk("mon_bat", current_monitor_output_select_battery, monitor_battery);
    chk("t2", model_q[1], dcm_t2_interval_select);
    chk("adc", model_q[0] || (adapter_present_flag && charging_active), adc_run);
  endtask
  task automatic write_settle(input logic [15:0] v, input int gap);
    host.wr(8'h4c, v, gap);
    model_q = v;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    $display("BAD watchdog expected finish seen hang");
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h302f8c8b));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    model_q = 16'h0300;
    model_lim = 8'h00;
    repeat (2) @(posedge ref_clk);
    #1;
    check_outputs();
    host.rd(8'h4c, d, h);
    chk("rdata", model_q, d);
    $display("test reset_values done");
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      w = 16'($urandom) & 16'hfffb;
      w[12:11] = i[1:0];
      battery_absent_input <= 1'($urandom);
      charging_active <= 1'($urandom);
      ov_detected_debounced <= 1'($urandom);
      current_monitor_output_select_battery <= 1'($urandom);
      write_settle(w, i % 3);
      check_outputs();
      host.rd(8'h4c, d, h);
      chk("rdata", model_q, d);
      chk("hit", 1, h);
    end
    $display("test random_writes done");
    host.wr(8'h4d, ~model_q, 0);
    host.rd(8'h4c, d, h);
    chk("rdata", model_q, d);
    host.rd(8'h4d, d, h);
    chk("other_rdata", 0, d);
    chk("other_hit", 0, h);
    $display("test unmapped done");
    for (int k = 0; k < 2; k++) begin
      write_settle((model_q & 16'hbffb) | (k ? 16'h4000 : 16'h0000), k);
      @(posedge ref_clk);
      lim = 8'($urandom);
      config_resistor_limit <= lim;
      b = reload_cnt;
      repeat (2) @(posedge ref_clk);
      adapter_present_flag <= 1'b0;
      if (k == 0) model_lim = lim;
      repeat (4) @(posedge ref_clk);
      #1;
      chk("limit", model_lim, adapter_limit_one_reg);
      chk("reloads", k ? 0 : 1, reload_cnt - b);
      check_outputs();
      @(posedge ref_clk);
      adapter_present_flag <= 1'b1;
    end
    $display("test adapter_reload done");
    for (int k = 0; k < 2; k++) begin
      write_settle(model_q | 16'h0080, 0);
      @(posedge ref_clk);
      if (k) fault_any <= 1'b1;
      else charge_timer_12h_expired <= 1'b1;
      @(posedge ref_clk);
      fault_any <= 1'b0;
      charge_timer_12h_expired <= 1'b0;
      model_q[7] = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      check_outputs();
      host.rd(8'h4c, d, h);
      chk("rdata", model_q, d);
    end
    $display("test auto_clear done");
    @(posedge ref_clk);
    lim = 8'($urandom);
    config_resistor_limit <= lim;
    b = reread_cnt;
    p = pulse_cnt;
    host.wr(8'h4c, model_q | 16'hf404, 1);
    host.wr(8'h4c, 16'h0001, 0);
    model_q = 16'h0300;
    model_lim = lim;
    repeat (10) @(posedge ref_clk);
    #1;
    check_outputs();
    chk("limit", model_lim, adapter_limit_one_reg);
    chk("rereads", 1, reread_cnt - b);
    chk("pulses", cc3_pkg::CC3_DRESET_CY, pulse_cnt - p);
    host.rd(8'h4c, d, h);
    chk("rdata", model_q, d);
    $display("test digital_reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
